// ---- common/rwc_pkg.sv ----
// Package for the reset and watchdog controller: register map, field positions,
// reset values and timing constants.
// Assumes a 25 MHz bus clock and a slower RC tick arriving from outside.
package rwc_pkg;

  localparam int unsigned CLK_HZ            = 25000000;
  // Nominal periods in microseconds and their counts in RC ticks.
  localparam int unsigned RC_TICK_HZ        = 1000000;
  localparam int unsigned DELAY_LONG_US     = 18000;
  localparam int unsigned DELAY_SHORT_US    = 300;
  localparam int unsigned WDOG_BASE_US      = 18000;
  localparam int unsigned DELAY_LONG_TICKS  = DELAY_LONG_US * (RC_TICK_HZ / 1000000);
  localparam int unsigned DELAY_SHORT_TICKS = DELAY_SHORT_US * (RC_TICK_HZ / 1000000);
  localparam int unsigned WDOG_BASE_TICKS   = WDOG_BASE_US * (RC_TICK_HZ / 1000000);

  // Register byte addresses.
  localparam logic [7:0] ADDR_OPTION = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CTRL   = 8'h08;

  localparam logic [7:0] OPTION_RESET = 8'hff;

  // Option register fields.
  localparam int unsigned OPT_PRESCALER_ASSIGN = 3;
  localparam int unsigned OPT_PRESCALE_SEL_LO  = 0;

  // Status register fields.
  localparam int unsigned STAT_PIN_WAKE   = 7;
  localparam int unsigned STAT_TIMEOUT_N  = 4;
  localparam int unsigned STAT_POWERDN_N  = 3;
  localparam int unsigned STAT_IN_RESET   = 0;
  localparam int unsigned STAT_SLEEPING   = 1;

  // Control register command bits, write one to trigger.
  localparam int unsigned CTRL_CLEAR_OP   = 0;
  localparam int unsigned CTRL_SLEEP_OP   = 1;

  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  // Oscillator configuration encodings.
  typedef enum logic [1:0] {
    RWC_OSC_LP    = 2'b00,
    RWC_OSC_XT    = 2'b01,
    RWC_OSC_INTERNAL_RC_MODE = 2'b10,
    RWC_OSC_EXTERNAL_RC_MODE = 2'b11
  } rwc_osc_t;

endpackage

// ---- verilog/rwc_reset_watchdog_control.sv ----
// Reset latch, start-up delay timer, watchdog, prescaler and reset-cause flags.
// Assumes aclk is always running; rc_clk and the pins are asynchronous and synchronised here.
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module rwc_reset_watchdog_control
  import rwc_pkg::*;
#(
  parameter int unsigned DELAY_LONG  = rwc_pkg::DELAY_LONG_TICKS,
  parameter int unsigned DELAY_SHORT = rwc_pkg::DELAY_SHORT_TICKS,
  parameter int unsigned WDOG_BASE   = rwc_pkg::WDOG_BASE_TICKS
)(
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Dedicated RC oscillator and analog / pin inputs (asynchronous).
  input  wire logic        rc_clk,
  input  wire logic        power_on_detect,
  input  wire logic        ext_reset_n,
  input  wire logic        pin_change,
  // Configuration word.
  input  wire logic        watchdog_enable_cfg,
  input  wire logic        ext_reset_enable_cfg,
  input  wire rwc_pkg::rwc_osc_t osc_cfg,
  // Core side.
  output logic             core_reset,
  output logic             main_osc_run,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import rwc_pkg::*;

  // Last prescaler count before the watchdog steps: a select of n divides by two to the n.
  function automatic logic [7:0] prescale_limit(input logic [2:0] sel);
    prescale_limit = 8'(({1'b0, 7'h7f} >> (3'd7 - sel)));
  endfunction

  // Two-flop synchronisers; only the second stage is read.
  // The RC clock gets a third stage so that its rising edge can be found.
  logic [1:0] por_s_r;
  logic [1:0] ext_s_r;
  logic [1:0] pin_s_r;
  logic [2:0] rc_s_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      por_s_r <= 2'h3;
      ext_s_r <= 2'h0;
      pin_s_r <= 2'h0;
      rc_s_r  <= 3'h0;
    end
    else
    begin
      por_s_r <= {por_s_r[0], power_on_detect};
      ext_s_r <= {ext_s_r[0], ext_reset_n};
      pin_s_r <= {pin_s_r[0], pin_change};
      rc_s_r  <= {rc_s_r[1:0], rc_clk};
    end
  end
  logic por_q;
  logic ext_low;
  logic pin_q;
  logic rc_tick;
  logic ext_low_d_r;
  assign por_q   = por_s_r[1];
  assign ext_low = ext_reset_enable_cfg && !ext_s_r[1];
  assign pin_q   = pin_s_r[1];
  assign rc_tick = rc_s_r[1] && !rc_s_r[2];

  // Register state.
  logic [7:0] option_r;
  logic       pin_wake_flag_r;
  logic       timeout_flag_n_r;
  logic       powerdown_flag_n_r;
  logic       sleeping_r;
  logic       latch_r;
  logic       por_seen_r;
  logic [31:0] delay_cnt_r;
  logic [31:0] wdog_cnt_r;
  logic [7:0]  presc_cnt_r;
  logic       clear_op;
  logic       sleep_op;
  logic       wdog_timeout;
  logic       wake_pin;
  logic       wake_ext;
  logic       delay_done;
  logic [31:0] delay_len;
  logic       crystal;

  assign crystal    = (osc_cfg == RWC_OSC_XT) || (osc_cfg == RWC_OSC_LP);
  // The long delay follows power-on and every reset in the crystal modes.
  assign delay_len  = (por_seen_r || crystal) ? DELAY_LONG : DELAY_SHORT;
  assign delay_done = delay_cnt_r >= delay_len;
  assign wake_pin   = sleeping_r && pin_q;
  assign wake_ext   = ext_low;

  // Watchdog counter and prescaler, stepping on RC ticks in every state except while the reset latch is set, which holds them clear.
  logic presc_wrap;
  logic wdog_clear;
  assign presc_wrap = !option_r[OPT_PRESCALER_ASSIGN] ||
                      (presc_cnt_r == prescale_limit(option_r[2:0]));
  assign wdog_timeout = watchdog_enable_cfg && rc_tick && presc_wrap &&
                        (wdog_cnt_r == WDOG_BASE - 1) && !latch_r;
  assign wdog_clear = clear_op || sleep_op || wdog_timeout || latch_r ||
                      (sleeping_r && (wake_pin || wake_ext));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wdog_cnt_r  <= 32'h0;
      presc_cnt_r <= 8'h0;
    end
    else if (wdog_clear)
    begin
      wdog_cnt_r  <= 32'h0;
      presc_cnt_r <= 8'h0;
    end
    else if (rc_tick)
    begin
      presc_cnt_r <= presc_wrap ? 8'h0 : presc_cnt_r + 8'h1;
      if (presc_wrap)
        wdog_cnt_r <= wdog_cnt_r + 32'h1;
    end
  end

  // Reset latch and start-up delay timer.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      latch_r     <= 1'b1;
      por_seen_r  <= 1'b1;
      delay_cnt_r <= 32'h0;
    end
    else if (por_q)
    begin
      latch_r     <= 1'b1;
      por_seen_r  <= 1'b1;
      delay_cnt_r <= 32'h0;
    end
    else if (wdog_timeout || wake_pin)
    begin
      latch_r     <= crystal || wake_pin;
      delay_cnt_r <= 32'h0;
    end
    else if (ext_low)
    begin
      latch_r     <= 1'b1;
      delay_cnt_r <= 32'h0;
    end
    else if (latch_r)
    begin
      if (delay_done)
      begin
        latch_r    <= 1'b0;
        por_seen_r <= 1'b0;
      end
      else if (rc_tick)
        delay_cnt_r <= delay_cnt_r + 32'h1;
    end
  end

  // Sleep state; the main oscillator stops while asleep.
  // Any reset cause ends sleep.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sleeping_r <= 1'b0;
    else if (por_q || ext_low || wdog_timeout || wake_pin || latch_r)
      sleeping_r <= 1'b0;
    else if (sleep_op)
      sleeping_r <= 1'b1;
  end
  assign main_osc_run = !sleeping_r;
  // A watchdog time-out resets the core for at least the cycle in which it fires. In RC
  // modes the latch stays clear unless a pin wake comes in the same cycle, so this one-cycle pulse is the whole device reset.
  assign core_reset   = por_q || ext_low || latch_r || wdog_timeout;

  // Reset-cause flags. Where two events meet in one cycle the higher branch wins, in the order
  // power-on, time-out, pin wake, external reset, sleep, clear.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_wake_flag_r    <= 1'b0;
      timeout_flag_n_r   <= 1'b1;
      powerdown_flag_n_r <= 1'b1;
    end
    else if (por_q)
    begin
      pin_wake_flag_r    <= 1'b0;
      timeout_flag_n_r   <= 1'b1;
      powerdown_flag_n_r <= 1'b1;
    end
    else if (wdog_timeout)
    begin
      pin_wake_flag_r  <= 1'b0;
      timeout_flag_n_r <= 1'b0;
    end
    else if (wake_pin)
    begin
      pin_wake_flag_r    <= 1'b1;
      timeout_flag_n_r   <= 1'b1;
      powerdown_flag_n_r <= 1'b0;
    end
    else if (ext_low && !latch_r)
      pin_wake_flag_r <= 1'b0;
    else if (sleep_op)
    begin
      timeout_flag_n_r   <= 1'b1;
      powerdown_flag_n_r <= 1'b0;
    end
    else if (clear_op)
    begin
      timeout_flag_n_r   <= 1'b1;
      powerdown_flag_n_r <= 1'b1;
    end
  end

  // AXI4-Lite write side: address and data taken in either order.
  // A write to the control register acts for one cycle, once both halves are held.
  logic       aw_held_r;
  logic       w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic       do_write;
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign do_write      = aw_held_r && w_held_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      aw_addr_r    <= 8'h0;
      w_data_r     <= 32'h0;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_r[7:2] <= ADDR_CTRL[7:2]) ? AXI_OKAY : AXI_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  assign clear_op = do_write && (aw_addr_r[7:2] == ADDR_CTRL[7:2]) && w_strb_r[0] &&
                    w_data_r[CTRL_CLEAR_OP] && !core_reset;
  assign sleep_op = do_write && (aw_addr_r[7:2] == ADDR_CTRL[7:2]) && w_strb_r[0] &&
                    w_data_r[CTRL_SLEEP_OP] && !core_reset;

  // Option register; returns to all ones on every core reset.
  // Writes while the core is held in reset are lost.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      option_r <= OPTION_RESET;
    else if (core_reset)
      option_r <= OPTION_RESET;
    else if (do_write && (aw_addr_r[7:2] == ADDR_OPTION[7:2]) && w_strb_r[0])
      option_r <= w_data_r[7:0];
  end

  // AXI4-Lite read side.
  // Unmapped addresses read as zero with an error response.
  logic [31:0] rd_word;
  always_comb
  begin
    rd_word = 32'h0;
    case (s_axi_araddr[7:2])
      ADDR_OPTION[7:2]: rd_word = {24'h0, option_r};
      ADDR_STATUS[7:2]:
      begin
        rd_word[STAT_PIN_WAKE]  = pin_wake_flag_r;
        rd_word[STAT_TIMEOUT_N] = timeout_flag_n_r;
        rd_word[STAT_POWERDN_N] = powerdown_flag_n_r;
        rd_word[STAT_SLEEPING]  = sleeping_r;
        rd_word[STAT_IN_RESET]  = core_reset;
      end
      default: rd_word = 32'h0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= AXI_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= (s_axi_araddr[7:2] <= ADDR_CTRL[7:2]) ? AXI_OKAY : AXI_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule
`default_nettype wire

// ---- testbench/rwc_reset_watchdog_control_assertions.sv ----
// Checker for the reset and watchdog controller: reset hold, start-up delay, wake, bus.
// Assumes each half period of rc_clk spans at least three aclk periods.
`timescale 1ns/1ps
`default_nettype none
module rwc_assertions
  import rwc_pkg::*;
#(
  parameter int unsigned DELAY_LONG  = 20,
  parameter int unsigned DELAY_SHORT = 5,
  parameter int unsigned WDOG_BASE   = 10
)(
  // Clock, reset and pins.
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              rc_clk,
  input wire logic              power_on_detect,
  input wire logic              ext_reset_n,
  input wire logic              pin_change,
  input wire logic              ext_reset_enable_cfg,
  input wire rwc_pkg::rwc_osc_t osc_cfg,
  // Core side.
  input wire logic              core_reset,
  input wire logic              main_osc_run,
  // Read channel.
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready
);
  logic [2:0] rc_s_r;
  logic [15:0] ticks_r;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // RC ticks seen while the core is held in reset, since the reset pin and power detect last let go.
  always_ff @(posedge aclk)
  begin
    rc_s_r <= {rc_s_r[1:0], rc_clk};
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !core_reset || power_on_detect || (ext_reset_enable_cfg && !ext_reset_n))
      ticks_r <= 16'h0000;
    else if (rc_s_r[1] && !rc_s_r[2] && ticks_r != 16'hffff)
      ticks_r <= ticks_r + 16'h0001;
  end
  sequence pin_wake_s;
    (!main_osc_run && pin_change)[*3];
  endsequence
  por_hold_a:
    assert property (power_on_detect |-> ##[0:3] core_reset)
    else $error("core not held while power detect is high");
  pin_hold_a:
    assert property ((ext_reset_enable_cfg && !ext_reset_n)[*4] |-> core_reset)
    else $error("core not held while reset pin is low");
  delay_long_a:
    assert property ($fell(core_reset) && !osc_cfg[1] |-> ticks_r >= DELAY_LONG - 2)
    else $error("crystal start-up delay too short");
  delay_short_a:
    assert property ($fell(core_reset) && osc_cfg[1] && $past(core_reset, 2) |->
                     ticks_r >= DELAY_SHORT - 2)
    else $error("rc start-up delay too short");
  wake_reset_a:
    assert property (pin_wake_s |-> ##[0:4] core_reset)
    else $error("pin change did not wake with a reset");
  sleep_gate_a:
    assert property ($fell(main_osc_run) |-> !core_reset)
    else $error("oscillator stopped while core in reset");
  rd_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  ar_block_a:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while response pending");
endmodule
bind rwc_reset_watchdog_control rwc_assertions #(.DELAY_LONG(DELAY_LONG),
  .DELAY_SHORT(DELAY_SHORT), .WDOG_BASE(WDOG_BASE)) u_rwc_assertions (
  .aclk(aclk), .aresetn(aresetn), .rc_clk(rc_clk), .power_on_detect(power_on_detect),
  .ext_reset_n(ext_reset_n), .pin_change(pin_change), .osc_cfg(osc_cfg),
  .ext_reset_enable_cfg(ext_reset_enable_cfg), .core_reset(core_reset),
  .main_osc_run(main_osc_run), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// ---- testbench/rwc_core_model.sv ----
// Model of the processor core held in reset: counts each release from reset.
// Assumes core_reset is a level on aclk.
`timescale 1ns/1ps
`default_nettype none
module rwc_core_model (
  // Clock and reset from the controller.
  input wire logic aclk,
  input wire logic core_reset,
  // Releases seen so far.
  output var int   boots
);
  logic held_r = 1'b0;
  int   n_r = 0;
  assign boots = n_r;
  always_ff @(posedge aclk)
  begin
    held_r <= core_reset;
    if (held_r && !core_reset)
      n_r <= n_r + 1;
  end
endmodule
`default_nettype wire

// ---- testbench/tb_reset_watchdog_control.sv ----
// Testbench for the reset and watchdog controller: boot, watchdog, sleep, wake, flags.
// Assumes scaled delays of 20, 5 and 10 RC ticks and an RC tick of about ten aclk.
`timescale 1ns/1ps
`default_nettype none
module tb_reset_watchdog_control;
  import rwc_pkg::*;
  localparam int unsigned DL = 20;
  localparam int unsigned DS = 5;
  localparam int unsigned WB = 10;
  logic aclk, aresetn, rc_clk, power_on_detect, ext_reset_n, pin_change;
  logic watchdog_enable_cfg, ext_reset_enable_cfg, core_reset, main_osc_run;
  rwc_osc_t osc_cfg;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc;
  int boots;
  rwc_reset_watchdog_control #(.DELAY_LONG(DL), .DELAY_SHORT(DS), .WDOG_BASE(WB))
    u_rwc_reset_watchdog_control (
    .aclk(aclk), .aresetn(aresetn), .rc_clk(rc_clk), .power_on_detect(power_on_detect),
    .ext_reset_n(ext_reset_n), .pin_change(pin_change), .osc_cfg(osc_cfg),
    .watchdog_enable_cfg(watchdog_enable_cfg), .ext_reset_enable_cfg(ext_reset_enable_cfg),
    .core_reset(core_reset), .main_osc_run(main_osc_run), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_rdata(s_axi_rdata),
    .s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  rwc_core_model u_rwc_core_model (.aclk(aclk), .core_reset(core_reset), .boots(boots));
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (aw || w)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) aw = 1'b0;
      if (s_axi_wready === 1'b1) w = 1'b0;
      s_axi_awvalid <= aw;
      s_axi_wvalid  <= w;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(AXI_OKAY));
  endtask
  task axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  task st(input logic [31:0] e);
    axr(ADDR_STATUS);
    chk(rd & 32'h98, e);
  endtask
  task wrst(input logic v);
    cyc = 0;
    while (core_reset !== v && cyc < 3000)
    begin
      @(posedge aclk);
      cyc++;
    end
    chk(32'(core_reset), 32'(v));
  endtask
  task t_por();
    power_on_detect <= 1'b0;
    repeat (50) @(posedge aclk);
    chk(32'(core_reset), 32'h1);
    ext_reset_n <= 1'b1;
    wrst(1'b0);
    chk(32'(cyc >= (DL - 1) * 10), 32'h1);
    axr(ADDR_OPTION);
    chk(rd, 32'hff);
    st(32'h18);
  endtask
  task t_wdog();
    axw(ADDR_OPTION, 32'h09);
    axw(ADDR_CTRL, 32'h01);
    wrst(1'b1);
    chk(32'(cyc > WB * 20 - 30 && cyc < WB * 20 + 30), 32'h1);
    wrst(1'b0);
    st(32'h08);
  endtask
  task t_clear();
    axw(ADDR_OPTION, 32'h09);
    repeat (4)
    begin
      axw(ADDR_CTRL, 32'h01);
      repeat (120) @(posedge aclk);
      chk(32'(core_reset), 32'h0);
    end
    st(32'h18);
  endtask
  task t_sleep();
    axw(ADDR_CTRL, 32'h01);
    repeat (150) @(posedge aclk);
    axw(ADDR_CTRL, 32'h02);
    repeat (2) @(posedge aclk);
    chk(32'(main_osc_run), 32'h0);
    wrst(1'b1);
    chk(32'(cyc > WB * 20 - 30), 32'h1);
    wrst(1'b0);
    st(32'h00);
  endtask
  task t_ext(input logic slp, input logic [31:0] e);
    if (slp) axw(ADDR_CTRL, 32'h02);
    repeat (20) @(posedge aclk);
    ext_reset_n <= 1'b0;
    repeat (10) @(posedge aclk);
    chk(32'(core_reset), 32'h1);
    ext_reset_n <= 1'b1;
    wrst(1'b0);
    st(e);
  endtask
  task t_pin(input int lo, input int hi);
    axw(ADDR_CTRL, 32'h02);
    repeat (20) @(posedge aclk);
    pin_change <= 1'b1;
    wrst(1'b1);
    pin_change <= 1'b0;
    wrst(1'b0);
    chk(32'(cyc >= lo && cyc <= hi), 32'h1);
    st(32'h90);
  endtask
  task t_rcwd();
    axw(ADDR_OPTION, 32'h08);
    axw(ADDR_CTRL, 32'h01);
    wrst(1'b1);
    chk(32'(cyc > WB * 10 - 30 && cyc < WB * 10 + 30), 32'h1);
    wrst(1'b0);
    chk(32'(cyc <= 2), 32'h1);
    axr(ADDR_OPTION);
    chk(rd, 32'hff);
    st(32'h08);
  endtask
  task t_cfg();
    ext_reset_enable_cfg <= 1'b0;
    watchdog_enable_cfg  <= 1'b0;
    ext_reset_n          <= 1'b0;
    axw(ADDR_OPTION, 32'h00);
    axw(ADDR_CTRL, 32'h01);
    repeat (400) @(posedge aclk);
    chk(32'(core_reset), 32'h0);
    ext_reset_n <= 1'b1;
    axr(8'h0c);
    chk(32'(rr), 32'(AXI_SLVERR));
    chk(rd, 32'h0);
    chk(boots, 32'd8);
  endtask
  task finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial
  begin
    rc_clk = 1'b0;
    #13;
    forever #200 rc_clk = ~rc_clk;
  end
  initial
  begin
    #800000;
    n_mismatch++;
    finish_test();
  end
  initial
  begin
    {aresetn, ext_reset_n, pin_change, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {power_on_detect, watchdog_enable_cfg, ext_reset_enable_cfg} = 3'h7;
    osc_cfg = RWC_OSC_XT;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_por();
    t_wdog();
    t_clear();
    t_sleep();
    t_ext(1'b1, 32'h10);
    t_pin((DL - 1) * 10, DL * 10 + 40);
    osc_cfg <= RWC_OSC_LP;
    t_ext(1'b0, 32'h10);
    osc_cfg <= RWC_OSC_INTERNAL_RC_MODE;
    t_pin((DS - 1) * 10, DS * 10 + 40);
    t_rcwd();
    t_cfg();
    finish_test();
  end
endmodule
`default_nettype wire
